/* File: umls_pkg.sv */
// shared constants and carriers for the uart modem and line status block
package umls_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_DATA = 8'h00;      // rx holding read, tx holding write
  localparam logic [7:0] OFS_IER = 8'h04;       // interrupt_enable
  localparam logic [7:0] OFS_FIFO_CTL = 8'h08;  // fifo enable and fifo resets
  localparam logic [7:0] OFS_FEATURE_CONTROL = 8'h0C;      // feature_control
  localparam logic [7:0] OFS_MCR = 8'h10;       // modem_control
  localparam logic [7:0] OFS_LSR = 8'h14;       // line_status
  localparam logic [7:0] OFS_MSR = 8'h18;       // modem_status
  localparam logic [7:0] OFS_SCR = 8'h1C;       // scratch_storage / enhanced_mode_select
  localparam logic [7:0] OFS_EFR = 8'h20;       // enhanced_feature
  localparam logic [7:0] OFS_TRIG = 8'h24;      // rx trigger level for auto rts

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;      // all control registers but the rx trigger level
  localparam logic [7:0] RST_TRIG = 8'h01;      // rx trigger level
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // modem_control field positions
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_AUX1 = 2;
  localparam int MCR_AUX2 = 3;
  localparam int MCR_LOOP = 4;

  // other field positions
  localparam int FIFO_EN = 0;                    // fifo control: enable
  localparam int FIFO_RX_RST = 1;                // fifo control: rx reset
  localparam int FIFO_TX_RST = 2;                // fifo control: tx reset
  localparam int IER_MODEM = 3;                  // modem status interrupt enable
  localparam int EFR_ARTS = 6;                   // auto rts enable
  localparam int EFR_ACTS = 7;                   // auto cts enable
  localparam int FEATURE_CONTROL_SWAP = 6;                  // scratchpad swap
  localparam int ENHANCED_MODE_SELECT_SEL0 = 0;                  // level counter select bit 0
  localparam int ENHANCED_MODE_SELECT_SEL1 = 1;                  // level counter select bit 1

  // auto rts hysteresis in characters, indexed by {enhanced_mode_select[5:4], feature_control[1:0]}
  localparam logic [15:0][5:0] HYST_TBL = {
    6'h24, 6'h1c, 6'h14, 6'h0c, 6'h34, 6'h30, 6'h2c, 6'h28,
    6'h20, 6'h18, 6'h10, 6'h08, 6'h08, 6'h06, 6'h04, 6'h00
  };

  // one received character from the deserialiser
  typedef struct packed {
    logic [7:0] data;     // character bits
    logic parity_err;     // parity mismatch
    logic frame_err;      // stop bit missing
    logic brk;            // line held low for a whole frame
  } umls_rx_char_s;

  // modem handshake inputs, all active low
  typedef struct packed {
    logic carrier_in_n;   // carrier detect
    logic ring_in_n;      // ring indicator
    logic dsr_in_n;       // data set ready
    logic cts_in_n;       // clear to send
  } umls_modem_in_s;

endpackage

/* File: umls_top.sv */
// uart modem control, line status, modem status and scratchpad block
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
module umls_top
  import umls_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int ADDR_W = 8
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receive side from the deserialiser
  input wire logic rx_in_valid,
  input wire umls_rx_char_s rx_in,
  // transmit side to the serialiser
  input wire logic tx_shift_busy,
  output logic tx_start,
  output logic [7:0] tx_data,
  output logic loopback_on,
  // modem pins
  input wire umls_modem_in_s modem_in,
  output logic dtr_out_n,
  output logic rts_out_n,
  output logic aux_out_two_n,
  output logic irq_out_en,
  output logic modem_irq
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] ONE_CNT = (AW+1)'(1);

  // whole module state
  typedef struct packed {
    logic [7:0] modem_control;                 // modem_control
    logic [7:0] interrupt_enable;                 // interrupt_enable
    logic fifo_en;                   // fifo mode
    logic [7:0] feature_control;                // feature_control
    logic [7:0] enhanced_feature;                 // enhanced_feature
    logic [7:0] enhanced_mode_select;                // enhanced_mode_select
    logic [7:0] scratch;             // scratch_storage
    logic [7:0] trig;                // rx trigger level
    logic [DEPTH-1:0][10:0] rx_mem;  // data and tags
    logic [AW-1:0] rx_rd;
    logic [AW-1:0] rx_wr;
    logic [AW:0] rx_cnt;
    logic [AW:0] rx_err_cnt;         // tagged entries held
    logic brk_hold;                  // last character offered was a break
    logic overrun;
    logic [DEPTH-1:0][7:0] tx_mem;
    logic [AW-1:0] tx_rd;
    logic [AW-1:0] tx_wr;
    logic [AW:0] tx_cnt;
    logic tx_start;
    logic [7:0] tx_data;
    logic [3:0] msr_prev;            // last seen status nibble
    logic [3:0] delta;               // change flags
    logic alt_tx;                    // next alternating read is tx
    logic rts_stop;                  // auto rts holding off
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic dtr_n;
    logic rts_n;
    logic aux2_n;
    logic irq_en;
    logic modem_irq;
  } umls_state_s;

  umls_state_s st_r;
  umls_state_s st_nxt;

  // outputs straight from state flops
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign tx_start = st_r.tx_start;
  assign tx_data = st_r.tx_data;
  assign loopback_on = st_r.modem_control[MCR_LOOP];
  assign dtr_out_n = st_r.dtr_n;
  assign rts_out_n = st_r.rts_n;
  assign aux_out_two_n = st_r.aux2_n;
  assign irq_out_en = st_r.irq_en;
  assign modem_irq = st_r.modem_irq;

  // next state
  always_comb begin
    logic [7:0] ofs;           // low address byte
    logic access;              // first access cycle, read data prepared
    logic done;                // completing edge of a transfer
    logic wr;                  // completing write with low lane enabled
    logic rd;                  // completing read
    logic [7:0] wbyte;         // written byte
    logic [3:0] msr_now;       // cts, dsr, ri, cd status
    logic [7:0] line_status;           // live line status
    logic [10:0] rx_head;      // head entry
    logic [AW:0] cap;          // fifo capacity in this mode
    logic rx_push;
    logic rx_pop;
    logic tx_push;
    logic tx_pop;
    logic push_tag;
    logic pop_tag;
    logic [7:0] flvl;          // selected fifo level
    logic [7:0] rd_byte;
    logic rd_ok;
    logic [5:0] hyst;
    logic [8:0] hi_mark;
    logic [8:0] lo_mark;
    logic [8:0] rx_lvl;
    logic cts_ok;
    st_nxt = st_r;
    // safe defaults for the locals from msr_now to cts_ok, overwritten below
    msr_now = 4'h0;
    line_status = 8'h00;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    push_tag = 1'b0;
    pop_tag = 1'b0;
    flvl = 8'h00;
    rd_byte = 8'h00;
    rd_ok = 1'b0;
    hyst = 6'h00;
    hi_mark = 9'h000;
    lo_mark = 9'h000;
    rx_lvl = 9'h000;
    cts_ok = 1'b0;
    ofs = paddr[7:0];
    access = psel & penable & ~st_r.pready;
    done = psel & penable & st_r.pready;
    wr = done & pwrite & pstrb[0];
    rd = done & ~pwrite;
    wbyte = pwdata[7:0];
    cap = st_r.fifo_en ? FULL_CNT : ONE_CNT;
    rx_head = st_r.rx_mem[st_r.rx_rd];

    // modem status: inverted pins or looped control bits
    if (st_r.modem_control[MCR_LOOP]) begin
      msr_now = {st_r.modem_control[MCR_AUX2], st_r.modem_control[MCR_AUX1], st_r.modem_control[MCR_DTR],
                 st_r.modem_control[MCR_RTS]};
    end else begin
      msr_now = ~{modem_in.carrier_in_n, modem_in.ring_in_n, modem_in.dsr_in_n,
                  modem_in.cts_in_n};
    end

    // live line status
    line_status[0] = (st_r.rx_cnt != '0);
    line_status[1] = st_r.overrun;
    line_status[2] = line_status[0] & rx_head[2];
    line_status[3] = line_status[0] & rx_head[1];
    line_status[4] = line_status[0] & rx_head[0];
    line_status[5] = (st_r.tx_cnt == '0);
    line_status[6] = (st_r.tx_cnt == '0) & ~tx_shift_busy & ~st_r.tx_start;
    line_status[7] = st_r.fifo_en & (st_r.rx_err_cnt != '0);

    // fifo level selection for swap reads
    if (~st_r.enhanced_mode_select[ENHANCED_MODE_SELECT_SEL0]) begin
      flvl = 8'(st_r.rx_cnt);
    end else if (~st_r.enhanced_mode_select[ENHANCED_MODE_SELECT_SEL1]) begin
      flvl = 8'(st_r.tx_cnt);
    end else begin
      flvl = st_r.alt_tx ? 8'(st_r.tx_cnt) : 8'(st_r.rx_cnt);
    end

    // read mux
    rd_ok = 1'b1;
    case (ofs)
      OFS_DATA: rd_byte = rx_head[10:3];
      OFS_IER: rd_byte = st_r.interrupt_enable;
      OFS_FIFO_CTL: rd_byte = {7'h00, st_r.fifo_en};
      OFS_FEATURE_CONTROL: rd_byte = st_r.feature_control;
      OFS_MCR: rd_byte = st_r.modem_control;
      OFS_LSR: rd_byte = line_status;
      OFS_MSR: rd_byte = {msr_now, st_r.delta};
      OFS_SCR: rd_byte = st_r.feature_control[FEATURE_CONTROL_SWAP] ? flvl : st_r.scratch;
      OFS_EFR: rd_byte = st_r.enhanced_feature;
      OFS_TRIG: rd_byte = st_r.trig;
      default: begin
        rd_byte = RST_BYTE;
        rd_ok = 1'b0;
      end
    endcase

    // apb handshake: data prepared in the first access cycle
    st_nxt.pready = access;
    if (access) begin
      st_nxt.prdata = pwrite ? RD_ZERO : {24'h00_0000, rd_byte};
      st_nxt.pslverr = ~rd_ok;
    end else if (done) begin
      st_nxt.prdata = RD_ZERO;
      st_nxt.pslverr = 1'b0;
    end

    // register writes
    if (wr) begin
      case (ofs)
        OFS_IER: st_nxt.interrupt_enable = wbyte;
        OFS_FIFO_CTL: st_nxt.fifo_en = wbyte[FIFO_EN];
        OFS_FEATURE_CONTROL: st_nxt.feature_control = wbyte;
        OFS_MCR: st_nxt.modem_control = wbyte;
        OFS_EFR: st_nxt.enhanced_feature = wbyte;
        OFS_TRIG: st_nxt.trig = wbyte;
        OFS_SCR: begin
          if (st_r.feature_control[FEATURE_CONTROL_SWAP]) begin
            st_nxt.enhanced_mode_select = wbyte;
            st_nxt.alt_tx = 1'b0;
          end else begin
            st_nxt.scratch = wbyte;
          end
        end
        default: begin
          st_nxt.interrupt_enable = st_nxt.interrupt_enable;
        end
      endcase
    end

    // alternating level counter steps on each scratch read while swap is on and both select bits are set
    if (rd && ofs == OFS_SCR && st_r.feature_control[FEATURE_CONTROL_SWAP] && (&st_r.enhanced_mode_select[1:0])) begin
      st_nxt.alt_tx = ~st_r.alt_tx;
    end

    // receive fifo
    rx_pop = rd && ofs == OFS_DATA && st_r.rx_cnt != '0;
    rx_push = 1'b0;
    if (rx_in_valid) begin
      if (rx_in.brk && st_r.brk_hold && st_r.fifo_en) begin
        rx_push = 1'b0;
      end else if (st_r.rx_cnt >= cap && !rx_pop) begin
        st_nxt.overrun = 1'b1;
      end else begin
        rx_push = 1'b1;
      end
      st_nxt.brk_hold = rx_in.brk;
    end
    // overrun clears only if it was reported; a new one wins
    if (rd && ofs == OFS_LSR && st_r.prdata[1] && !(rx_in_valid && !rx_push
        && !(rx_in.brk && st_r.brk_hold && st_r.fifo_en))) begin
      st_nxt.overrun = 1'b0;
    end
    push_tag = rx_push & (rx_in.parity_err | rx_in.frame_err | rx_in.brk);
    pop_tag = rx_pop & (|rx_head[2:0]);
    if (rx_push) begin
      st_nxt.rx_mem[st_r.rx_wr] = {rx_in.data, rx_in.parity_err, rx_in.frame_err,
                                   rx_in.brk};
      st_nxt.rx_wr = st_r.rx_wr + 1'b1;
    end
    if (rx_pop) begin
      st_nxt.rx_rd = st_r.rx_rd + 1'b1;
    end
    st_nxt.rx_cnt = st_r.rx_cnt + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    st_nxt.rx_err_cnt = st_r.rx_err_cnt + (AW+1)'(push_tag) - (AW+1)'(pop_tag);

    // transmit fifo
    cts_ok = ~st_r.enhanced_feature[EFR_ACTS] | msr_now[0];
    tx_pop = ~st_r.tx_start & ~tx_shift_busy & (st_r.tx_cnt != '0) & cts_ok;
    tx_push = wr && ofs == OFS_DATA && (st_r.tx_cnt < cap || tx_pop);
    st_nxt.tx_start = tx_pop;
    if (tx_pop) begin
      st_nxt.tx_data = st_r.tx_mem[st_r.tx_rd];
      st_nxt.tx_rd = st_r.tx_rd + 1'b1;
    end
    if (tx_push) begin
      st_nxt.tx_mem[st_r.tx_wr] = wbyte;
      st_nxt.tx_wr = st_r.tx_wr + 1'b1;
    end
    st_nxt.tx_cnt = st_r.tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);

    // fifo resets, self clearing
    if (wr && ofs == OFS_FIFO_CTL && wbyte[FIFO_RX_RST]) begin
      st_nxt.rx_rd = '0;
      st_nxt.rx_wr = '0;
      st_nxt.rx_cnt = '0;
      st_nxt.rx_err_cnt = '0;
    end
    if (wr && ofs == OFS_FIFO_CTL && wbyte[FIFO_TX_RST]) begin
      st_nxt.tx_rd = '0;
      st_nxt.tx_wr = '0;
      st_nxt.tx_cnt = '0;
    end

    // modem change flags: clear reported bits, new change wins
    st_nxt.msr_prev = msr_now;
    if (rd && ofs == OFS_MSR) begin
      st_nxt.delta = st_r.delta & ~st_r.prdata[3:0];
    end
    if (msr_now[0] != st_r.msr_prev[0]) begin
      st_nxt.delta[0] = 1'b1;
    end
    if (msr_now[1] != st_r.msr_prev[1]) begin
      st_nxt.delta[1] = 1'b1;
    end
    if (!msr_now[2] && st_r.msr_prev[2]) begin
      st_nxt.delta[2] = 1'b1;
    end
    if (msr_now[3] != st_r.msr_prev[3]) begin
      st_nxt.delta[3] = 1'b1;
    end
    st_nxt.modem_irq = st_r.interrupt_enable[IER_MODEM] & (|st_r.delta);

    // auto rts watermarks around the trigger level
    hyst = HYST_TBL[{st_r.enhanced_mode_select[5:4], st_r.feature_control[1:0]}];
    rx_lvl = 9'(st_r.rx_cnt);
    hi_mark = {1'b0, st_r.trig} + {3'h0, hyst};
    lo_mark = (st_r.trig > {2'h0, hyst}) ? {1'b0, st_r.trig - {2'h0, hyst}} : 9'h000;
    if (rx_lvl >= hi_mark) begin
      st_nxt.rts_stop = 1'b1;
    end else if (rx_lvl < lo_mark) begin
      st_nxt.rts_stop = 1'b0;
    end

    // dtr, rts and aux two pins, parked high during loopback
    if (st_r.modem_control[MCR_LOOP]) begin
      st_nxt.dtr_n = 1'b1;
      st_nxt.rts_n = 1'b1;
      st_nxt.aux2_n = 1'b1;
    end else begin
      st_nxt.dtr_n = ~st_r.modem_control[MCR_DTR];
      if (st_r.enhanced_feature[EFR_ARTS] && st_r.modem_control[MCR_RTS]) begin
        st_nxt.rts_n = st_r.rts_stop;
      end else begin
        st_nxt.rts_n = ~st_r.modem_control[MCR_RTS];
      end
      st_nxt.aux2_n = ~st_r.modem_control[MCR_AUX2];
    end
    st_nxt.irq_en = st_r.modem_control[MCR_AUX2];
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.trig <= RST_TRIG;
      st_r.dtr_n <= 1'b1;
      st_r.rts_n <= 1'b1;
      st_r.aux2_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

/* File: umls_top_asserts.sv */
// assertion checker for the modem and line status block
`timescale 1ns/1ns
module umls_asserts
  import umls_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int ADDR_W = 8
) (
  // apb side
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // transmit and modem side
  input wire logic tx_shift_busy, tx_start, loopback_on,
  input wire umls_modem_in_s modem_in,
  input wire logic dtr_out_n, aux_out_two_n, irq_out_en, modem_irq
);
  logic ien_r; // shadow of modem interrupt enable
  logic acts_r; // shadow of auto cts enable
  wire done_w = psel && penable && pready && pwrite && pstrb[0];
  // follow the enables the host writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_r <= 1'b0;
      acts_r <= 1'b0;
    end else begin
      if (done_w && paddr == OFS_IER) ien_r <= pwdata[IER_MODEM];
      if (done_w && paddr == OFS_EFR) acts_r <= pwdata[EFR_ACTS];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed modem_control write, normal pin mode
  sequence mcr_wr;
    done_w && paddr == OFS_MCR;
  endsequence
  sequence mcr_pins;
    mcr_wr ##0 !pwdata[MCR_LOOP];
  endsequence
  dtr_pin_a: assert property (mcr_pins |-> ##2 dtr_out_n == !$past(pwdata[MCR_DTR], 2))
    else $error("dtr pin does not follow control bit");
  aux_two_a: assert property (mcr_pins |-> ##2 aux_out_two_n == !$past(pwdata[MCR_AUX2], 2))
    else $error("aux two pin does not follow control bit");
  irq_gate_a: assert property (mcr_wr |-> ##2 irq_out_en == $past(pwdata[MCR_AUX2], 2))
    else $error("interrupt output enable wrong");
  loop_en_a: assert property (mcr_wr |=> loopback_on == $past(pwdata[MCR_LOOP]))
    else $error("loopback enable wrong");
  irq_mask_a: assert property ((!ien_r)[*2] |-> !modem_irq)
    else $error("modem interrupt while disabled");
  cts_irq_a: assert property ((ien_r && !loopback_on)[*3] ##0 $changed(modem_in.cts_in_n)
    |-> ##[1:3] modem_irq)
    else $error("cts change raised no modem interrupt");
  tx_busy_a: assert property (tx_start |-> !$past(tx_shift_busy) && !$past(tx_start))
    else $error("start while shifter busy");
  cts_hold_a: assert property ((acts_r && !loopback_on && modem_in.cts_in_n)[*3] |=> !tx_start)
    else $error("start while cts deasserted");
  wait_one_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  err_with_a: assert property (pslverr |-> pready)
    else $error("error response without ready");
endmodule
bind umls_top umls_asserts #(.DEPTH(DEPTH), .ADDR_W(ADDR_W)) umls_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .tx_shift_busy(tx_shift_busy), .tx_start(tx_start), .loopback_on(loopback_on),
  .modem_in(modem_in), .dtr_out_n(dtr_out_n), .aux_out_two_n(aux_out_two_n),
  .irq_out_en(irq_out_en), .modem_irq(modem_irq));

/* File: umls_partner.sv */
// serialiser model: shift timing and received character offers
`timescale 1ns/1ns
module umls_partner
  import umls_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // transmit handshake
  input wire logic tx_start,
  input wire logic slow,
  output logic tx_shift_busy,
  // receive offers asked for by the bench
  input wire logic inj_v,
  input wire umls_rx_char_s inj_c,
  output logic rx_in_valid,
  output umls_rx_char_s rx_in
);
  logic [3:0] cnt_r; // shift cycles left
  // busy from the cycle after a start, short or long frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= 4'h0;
    else if (tx_start) cnt_r <= slow ? 4'h9 : 4'h2;
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
  end
  assign tx_shift_busy = cnt_r != 4'h0;
  // character lines scrambled outside an offer
  assign rx_in_valid = inj_v;
  assign rx_in = inj_v ? inj_c : ~inj_c;
endmodule

/* File: test_uart_modem_line_status.sv */
// self-checking bench for the modem and line status block
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module test_uart_modem_line_status;
  import umls_pkg::*;
  // design ports
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, rx_in_valid, tx_shift_busy, tx_start, loopback_on, slow = 1'b0;
  logic dtr_out_n, rts_out_n, aux_out_two_n, irq_out_en, modem_irq, inj_v = 1'b0;
  logic [7:0] tx_data;
  umls_rx_char_s rx_in, inj_c = '0;
  umls_modem_in_s modem_in = 4'hf;
  // bench state
  int error_cnt = 0, checks = 0;
  logic [31:0] rv;
  logic er;
  logic [3:0] sp = 4'h0, dl = 4'h0; // expected status and deltas
  logic [7:0] txq[$];
  umls_top #(.DEPTH(4)) umls_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_in_valid(rx_in_valid), .rx_in(rx_in),
    .tx_shift_busy(tx_shift_busy), .tx_start(tx_start), .tx_data(tx_data),
    .loopback_on(loopback_on), .modem_in(modem_in), .dtr_out_n(dtr_out_n),
    .rts_out_n(rts_out_n), .aux_out_two_n(aux_out_two_n), .irq_out_en(irq_out_en),
    .modem_irq(modem_irq));
  umls_partner umls_partner_inst (.pclk(pclk), .presetn(presetn), .tx_start(tx_start),
    .slow(slow), .tx_shift_busy(tx_shift_busy), .inj_v(inj_v), .inj_c(inj_c),
    .rx_in_valid(rx_in_valid), .rx_in(rx_in));
  always #10 pclk = ~pclk;
  // log each byte handed to the serialiser
  always @(posedge pclk) if (tx_start) txq.push_back(tx_data);
  // one apb transfer, answer left in rv and er
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(nm, {24'h00_0000, e}, rv)
  endtask
  // modem status nibble seen by the block
  function automatic logic [3:0] stat(logic [4:0] m, umls_modem_in_s p);
    return m[MCR_LOOP] ? {m[3], m[2], m[0], m[1]} : ~p;
  endfunction
  // deltas: any change, ring only on its falling status
  function automatic void upd(logic [3:0] s);
    dl = dl | ((s ^ sp) & 4'hb) | {1'b0, sp[2] & ~s[2], 2'b00};
    sp = s;
  endfunction
  task automatic inj(input umls_rx_char_s c);
    @(posedge pclk);
    inj_v <= 1'b1;
    inj_c <= c;
    @(posedge pclk);
    inj_v <= 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    end_sim();
  end
  initial begin
    logic [4:0] m, mo;
    logic [7:0] m8;
    umls_modem_in_s p;
    umls_rx_char_s c[5];
    logic [7:0] le[4];
    void'($urandom(16589));
    mo = 5'h00;
    le = '{8'h85, 8'h01, 8'h01, 8'h00};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_MCR, 8'h00, "mcr_rst");
    rd(OFS_LSR, 8'h60, "lsr_rst");
    `CHK("pins_rst", 4'he, {dtr_out_n, rts_out_n, aux_out_two_n, irq_out_en})
    wr(OFS_IER, 8'h08);
    // random modem control and pin levels
    for (int i = 0; i < 16; i++) begin
      m = 5'($urandom);
      p = 4'($urandom);
      modem_in <= p;
      upd(stat(mo, p));
      wr(OFS_MCR, {3'b000, m});
      upd(stat(m, p));
      mo = m;
      repeat (3) @(posedge pclk);
      `CHK("dtr", ~m[0] | m[4], dtr_out_n)
      `CHK("rts", ~m[1] | m[4], rts_out_n)
      `CHK("aux2", ~m[3] | m[4], aux_out_two_n)
      `CHK("irq_en", m[3], irq_out_en)
      `CHK("loop", m[4], loopback_on)
      `CHK("mirq", |dl, modem_irq)
      rd(OFS_MSR, {stat(m, p), dl}, "msr");
      dl = 4'h0;
    end
    for (int i = 0; i < 4; i++) begin
      m8 = 8'($urandom);
      wr(OFS_SCR, m8);
      rd(OFS_SCR, m8, "scratch");
    end
    pstrb <= 4'h0;
    wr(OFS_SCR, ~m8);
    pstrb <= 4'hf;
    rd(OFS_SCR, m8, "strb");
    // fifo mode, cts deasserted, one character too many
    wr(OFS_MCR, 8'h00);
    wr(OFS_FIFO_CTL, 8'h01);
    modem_in <= 4'hf;
    wr(OFS_EFR, 8'h80);
    for (int i = 0; i < 5; i++) begin
      c[i] = '{8'($urandom), i == 1, 1'b0, 1'b0};
      inj(c[i]);
    end
    wr(OFS_DATA, 8'h5a);
    wr(OFS_DATA, 8'ha5);
    rd(OFS_LSR, 8'h83, "lsr_ovr");
    wr(OFS_FEATURE_CONTROL, 8'h40);
    wr(OFS_SCR, 8'h00);
    rd(OFS_SCR, 8'h04, "rx_lvl");
    wr(OFS_SCR, 8'h01);
    rd(OFS_SCR, 8'h02, "tx_lvl");
    wr(OFS_SCR, 8'h03);
    rd(OFS_SCR, 8'h04, "alt_rx");
    rd(OFS_SCR, 8'h02, "alt_tx");
    rd(OFS_SCR, 8'h04, "alt_rx2");
    wr(OFS_FEATURE_CONTROL, 8'h00);
    rd(OFS_SCR, m8, "kept");
    `CHK("held", 0, txq.size())
    for (int i = 0; i < 4; i++) begin
      rd(OFS_DATA, c[i].data, "rx_data");
      rd(OFS_LSR, le[i], "lsr_head");
    end
    // release cts, long frames
    slow <= 1'b1;
    modem_in <= 4'he;
    for (int k = 0; k < 200 && (txq.size() < 2 || tx_shift_busy || tx_start); k++)
      @(posedge pclk);
    `CHK("tx0", 8'h5a, txq[0])
    `CHK("tx1", 8'ha5, txq[1])
    rd(OFS_LSR, 8'h60, "lsr_idle");
    // two break characters, one stored
    inj('{8'h00, 1'b0, 1'b1, 1'b1});
    inj('{8'h00, 1'b0, 1'b1, 1'b1});
    rd(OFS_LSR, 8'hf9, "lsr_brk");
    rd(OFS_DATA, 8'h00, "brk_data");
    rd(OFS_LSR, 8'h60, "one_brk");
    apb(1'b0, 8'h80, 32'h0000_0000);
    `CHK("unmapped", 33'h1_0000_0000, {er, rv})
    wr(OFS_LSR, 8'h00);
    rd(OFS_LSR, 8'h60, "lsr_ro");
    // auto rts, trigger one, zero hysteresis
    wr(OFS_EFR, 8'h40);
    wr(OFS_MCR, 8'h02);
    repeat (3) @(posedge pclk);
    `CHK("rts_go", 1'b0, rts_out_n)
    inj('{8'h3c, 1'b0, 1'b0, 1'b0});
    repeat (3) @(posedge pclk);
    `CHK("rts_stop", 1'b1, rts_out_n)
    rd(OFS_DATA, 8'h3c, "rts_data");
    repeat (3) @(posedge pclk);
    `CHK("rts_again", 1'b0, rts_out_n)
    end_sim();
  end
endmodule
